//--- pkg/aack_pkg.sv
// shared constants and carrier types for the auto-ack frame filter
package aack_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ = 50;
  localparam int SYM_US = 16;
  localparam int SYM_CYCLES = CLK_MHZ * SYM_US;
  localparam int TRIG_US = 16;
  localparam int TRIG_CYCLES = CLK_MHZ * TRIG_US;
  localparam logic [3:0] ACK_STD_SYM = 4'hc;
  localparam logic [3:0] ACK_SHORT_SYM = 4'h2;
  localparam logic [3:0] SLOT_STD_SYM = 4'h6;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TRIG_OFS = 8'h04;
  localparam logic [7:0] PAN_OFS = 8'h08;
  localparam logic [7:0] SHORT_OFS = 8'h0c;
  localparam logic [7:0] EXT_LO_OFS = 8'h10;
  localparam logic [7:0] EXT_HI_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h040;
  localparam logic [15:0] PAN_RST = 16'hffff;
  localparam logic [15:0] SHORT_RST = 16'hffff;
  localparam logic [63:0] EXT_RST = 64'h0;
  localparam int TRIG_BIT = 0;

  // ==========================================================
  // frame fields
  localparam int HDR_BYTES = 23;
  localparam logic [15:0] BCAST = 16'hffff;
  localparam logic [2:0] FT_BEACON = 3'h0;
  localparam logic [2:0] FT_DATA = 3'h1;
  localparam logic [2:0] FT_ACK = 3'h2;
  localparam logic [2:0] FT_CMD = 3'h3;
  localparam logic [1:0] AM_SHORT = 2'h2;
  localparam logic [1:0] AM_EXT = 2'h3;
  localparam logic [1:0] VFM_ALL = 2'h3;

  // transaction_result codes
  localparam logic [2:0] TRAC_SUCCESS = 3'h0;
  localparam logic [2:0] TRAC_ACK_WAITING = 3'h2;
  localparam logic [2:0] TRAC_INVALID = 3'h7;

  typedef enum logic [2:0] {
    REG_CTRL = 3'b000, REG_TRIG = 3'b001, REG_PAN = 3'b010, REG_SHORT = 3'b011,
    REG_EXT_LO = 3'b100, REG_EXT_HI = 3'b101, REG_STATUS = 3'b110, REG_NONE = 3'b111
  } reg_sel_t;

  typedef struct packed {
    logic ami_en;
    logic dis_ack;
    logic [1:0] version_filter_mode;
    logic reserved_type_filter;
    logic reserved_type_upload;
    logic coord;
    logic ack_turnaround_select;
    logic slotted_ack_enable;
    logic auto_ack_receive_mode;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] pan_id;
    logic [15:0] short_addr;
    logic [63:0] ext_addr;
    logic coord;
    logic reserved_type_upload;
    logic reserved_type_filter;
    logic [1:0] version_filter_mode;
  } frame_cfg_t;

  typedef struct packed {
    logic accept;
    logic ami_ok;
    logic bypass;
    logic ack_req;
  } filt_res_t;

endpackage

//--- hdl/symbol_tick.sv
// restartable divider giving a one-cycle symbol enable
`timescale 1ns/1ps
module symbol_tick import aack_pkg::*; #(
  parameter int DIV = SYM_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tk_t;

  tk_t s_reg;
  tk_t s_next;

  // ==========================================================
  // counter
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    // restart keeps symbol edges aligned to the frame end
    if (clr) begin
      s_next.cnt = '0;
    end else if (s_reg.cnt == LAST) begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule // symbol_tick

//--- hdl/frame_filter.sv
// combinational third-level frame filter over a captured header
`timescale 1ns/1ps
module frame_filter import aack_pkg::*; (
  input wire logic [HDR_BYTES-1:0][7:0] hdr,
  input wire frame_cfg_t cfg,
  output filt_res_t res
);
  logic [2:0] ftype;
  logic [1:0] dmode;
  logic [1:0] smode;
  logic [1:0] ver;
  logic dst_pres;
  logic src_pres;
  logic rsv;
  logic datalike;
  logic [4:0] spos;
  logic [15:0] dpan;
  logic [15:0] span;
  logic ok_type;
  logic ok_ver;
  logic ok_pan;
  logic ok_addr;
  logic ok_beacon;
  logic ok_src;
  logic pass;

  // ==========================================================
  // filter
  always_comb begin
    ftype = hdr[0][2:0];
    dmode = hdr[1][3:2];
    ver = hdr[1][5:4];
    smode = hdr[1][7:6];
    dst_pres = dmode[1];
    src_pres = smode[1];
    rsv = ftype[2];
    datalike = (ftype == FT_DATA) || (ftype == FT_CMD) || rsv;
    dpan = {hdr[4], hdr[3]};
    spos = !dst_pres ? 5'd3 : ((dmode == AM_SHORT) ? 5'd7 : 5'd13);
    // compressed source pan reuses the destination pan
    span = hdr[0][6] ? dpan : {hdr[spos + 5'd1], hdr[spos]};
    ok_type = !rsv || (cfg.reserved_type_upload && cfg.reserved_type_filter);
    ok_ver = (cfg.version_filter_mode == VFM_ALL) || (ver <= cfg.version_filter_mode);
    ok_pan = !dst_pres || (dpan == cfg.pan_id) || (dpan == BCAST);
    if (dmode == AM_SHORT) begin
      ok_addr = ({hdr[6], hdr[5]} == cfg.short_addr) || ({hdr[6], hdr[5]} == BCAST);
    end else if (dmode == AM_EXT) begin
      ok_addr = {hdr[12], hdr[11], hdr[10], hdr[9], hdr[8], hdr[7], hdr[6], hdr[5]}
        == cfg.ext_addr;
    end else begin
      ok_addr = 1'b1;
    end
    ok_beacon = (ftype != FT_BEACON) || (cfg.pan_id == BCAST) || (src_pres && span == cfg.pan_id);
    ok_src = !(datalike && !dst_pres && src_pres) || (cfg.coord && span == cfg.pan_id);
    pass = ok_type && ok_ver && ok_pan && ok_addr && ok_beacon && ok_src && (ftype != FT_ACK);
    res.bypass = rsv && cfg.reserved_type_upload && !cfg.reserved_type_filter;
    res.accept = pass || res.bypass;
    res.ami_ok = pass && !res.bypass && !(!dst_pres && smode == 2'b00);
    res.ack_req = pass && !res.bypass && datalike && hdr[0][5];
  end
endmodule // frame_filter

//--- hdl/auto_ack_frame_filter.sv
// auto-ack receive mode: frame filter, ack turnaround timing, apb registers
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module auto_ack_frame_filter import aack_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_SFD,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_DONE,
  input wire logic RX_FCS_OK,
  input wire logic TX_DONE,
  output logic ACK_TX_START,
  output logic RX_START_IRQ,
  output logic ADDR_MATCH_IRQ,
  output logic RX_END_IRQ,
  output logic RX_BUSY
);

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK_WAIT = 3'b010,
    ST_ACK_SLOT = 3'b011,
    ST_ACK_TRIG = 3'b100,
    ST_ACK_TX = 3'b101
  } fsm_t;

  localparam logic [9:0] TRIG_LAST = 10'(TRIG_CYCLES - 1);
  localparam logic [4:0] HDR_N = 5'(HDR_BYTES);
  localparam logic [4:0] HDR_MIN = 5'd3;

  typedef struct packed {
    ctrl_t ctrl;
    logic [15:0] pan;
    logic [15:0] short_a;
    logic [63:0] ext;
    fsm_t fsm;
    logic [4:0] nbytes;
    logic [HDR_BYTES-1:0][7:0] hdr;
    logic [3:0] sym;
    logic [3:0] sym_target;
    logic [9:0] us;
    logic [2:0] trac;
    logic last_acc;
    logic last_ack;
    logic [31:0] prdata;
    logic pslverr;
    logic rx_start;
    logic ami;
    logic rx_end;
    logic ack_start;
  } st_t;

  st_t st_reg;
  st_t st_next;
  frame_cfg_t cfg;
  filt_res_t fres;
  logic sym_tick;
  logic sym_clr;
  logic wr;
  logic rd_setup;
  logic trig_wr;
  reg_sel_t sel;

  // ==========================================================
  // address decode, shared by read and write
  function automatic reg_sel_t reg_decode(input logic [7:0] a);
    reg_sel_t r;
    r = REG_NONE;
    if (a == CTRL_OFS) begin
      r = REG_CTRL;
    end else if (a == TRIG_OFS) begin
      r = REG_TRIG;
    end else if (a == PAN_OFS) begin
      r = REG_PAN;
    end else if (a == SHORT_OFS) begin
      r = REG_SHORT;
    end else if (a == EXT_LO_OFS) begin
      r = REG_EXT_LO;
    end else if (a == EXT_HI_OFS) begin
      r = REG_EXT_HI;
    end else if (a == STATUS_OFS) begin
      r = REG_STATUS;
    end
    return r;
  endfunction

  // ==========================================================
  // submodules
  assign cfg.pan_id = st_reg.pan;
  assign cfg.short_addr = st_reg.short_a;
  assign cfg.ext_addr = st_reg.ext;
  assign cfg.coord = st_reg.ctrl.coord;
  assign cfg.reserved_type_upload = st_reg.ctrl.reserved_type_upload;
  assign cfg.reserved_type_filter = st_reg.ctrl.reserved_type_filter;
  assign cfg.version_filter_mode = st_reg.ctrl.version_filter_mode;

  frame_filter u_filter (
    .hdr(st_reg.hdr),
    .cfg(cfg),
    .res(fres)
  );

  symbol_tick #(.DIV(SYM_CYCLES)) u_sym (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .clr(sym_clr),
    .tick(sym_tick)
  );

  // ==========================================================
  // apb strobes
  assign sel = reg_decode(PADDR);
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign trig_wr = wr && (sel == REG_TRIG) && PWDATA[TRIG_BIT];
  // frame end restarts the symbol divider so counts start there
  assign sym_clr = (st_reg.fsm == ST_RX) && RX_DONE;

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.rx_start = 1'b0;
    st_next.ami = 1'b0;
    st_next.rx_end = 1'b0;
    st_next.ack_start = 1'b0;

    // register writes take effect in the access cycle only
    if (wr) begin
      if (sel == REG_CTRL) begin
        st_next.ctrl = ctrl_t'(PWDATA[CTRL_W-1:0]);
      end else if (sel == REG_PAN) begin
        st_next.pan = PWDATA[15:0];
      end else if (sel == REG_SHORT) begin
        st_next.short_a = PWDATA[15:0];
      end else if (sel == REG_EXT_LO) begin
        st_next.ext[31:0] = PWDATA;
      end else if (sel == REG_EXT_HI) begin
        st_next.ext[63:32] = PWDATA;
      end
    end

    // read data prepared in setup so it stands through the access phase
    if (PSEL && !PENABLE) begin
      st_next.pslverr = (sel == REG_NONE);
    end
    if (rd_setup) begin
      st_next.prdata = '0;
      if (sel == REG_CTRL) begin
        st_next.prdata = {22'h0, st_reg.ctrl};
      end else if (sel == REG_PAN) begin
        st_next.prdata = {16'h0, st_reg.pan};
      end else if (sel == REG_SHORT) begin
        st_next.prdata = {16'h0, st_reg.short_a};
      end else if (sel == REG_EXT_LO) begin
        st_next.prdata = st_reg.ext[31:0];
      end else if (sel == REG_EXT_HI) begin
        st_next.prdata = st_reg.ext[63:32];
      end else if (sel == REG_STATUS) begin
        st_next.prdata = {23'h0, st_reg.last_ack, st_reg.last_acc, st_reg.trac,
          (st_reg.fsm != ST_IDLE), st_reg.fsm};
      end
    end

    if (sym_tick) begin
      st_next.sym = st_reg.sym + 4'h1;
    end

    case (st_reg.fsm)
      ST_IDLE: begin
        if (st_reg.ctrl.auto_ack_receive_mode && RX_SFD) begin
          st_next.fsm = ST_RX;
          st_next.nbytes = '0;
          st_next.hdr = '0;
          st_next.rx_start = 1'b1;
        end
      end
      ST_RX: begin
        if (RX_VALID && st_reg.nbytes < HDR_N) begin
          st_next.hdr[st_reg.nbytes] = RX_BYTE;
          st_next.nbytes = st_reg.nbytes + 5'd1;
        end
        if (RX_DONE) begin
          // runt frames are never accepted
          st_next.last_acc = fres.accept && st_reg.nbytes >= HDR_MIN;
          st_next.last_ack = 1'b0;
          st_next.sym = '0;
          st_next.ami = fres.ami_ok && st_reg.nbytes >= HDR_MIN && st_reg.ctrl.ami_en;
          st_next.rx_end = fres.accept && st_reg.nbytes >= HDR_MIN && RX_FCS_OK;
          st_next.fsm = ST_IDLE;
          if (fres.accept && fres.ack_req && st_reg.nbytes >= HDR_MIN && RX_FCS_OK
              && !st_reg.ctrl.dis_ack) begin
            st_next.last_ack = 1'b1;
            st_next.fsm = ST_ACK_WAIT;
            if (st_reg.ctrl.ack_turnaround_select) begin
              st_next.sym_target = ACK_SHORT_SYM;
            end else if (st_reg.ctrl.slotted_ack_enable) begin
              st_next.sym_target = SLOT_STD_SYM;
            end else begin
              st_next.sym_target = ACK_STD_SYM;
            end
          end
        end
      end
      ST_ACK_WAIT: begin
        if (sym_tick && st_reg.sym + 4'h1 == st_reg.sym_target) begin
          if (st_reg.ctrl.slotted_ack_enable) begin
            st_next.fsm = ST_ACK_SLOT;
            st_next.trac = TRAC_ACK_WAITING;
          end else begin
            st_next.fsm = ST_ACK_TX;
            st_next.ack_start = 1'b1;
          end
        end
      end
      ST_ACK_SLOT: begin
        // only the host trigger starts it
        if (trig_wr) begin
          st_next.fsm = ST_ACK_TRIG;
          st_next.us = '0;
        end
      end
      ST_ACK_TRIG: begin
        if (st_reg.us == TRIG_LAST) begin
          st_next.fsm = ST_ACK_TX;
          st_next.ack_start = 1'b1;
        end else begin
          st_next.us = st_reg.us + 10'd1;
        end
      end
      ST_ACK_TX: begin
        if (TX_DONE) begin
          st_next.fsm = ST_IDLE;
          st_next.trac = TRAC_SUCCESS;
        end
      end
      default: begin
        st_next.fsm = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= '0;
      st_reg.ctrl <= ctrl_t'(CTRL_RST);
      st_reg.pan <= PAN_RST;
      st_reg.short_a <= SHORT_RST;
      st_reg.ext <= EXT_RST;
      st_reg.fsm <= ST_IDLE;
      st_reg.trac <= TRAC_INVALID;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  // zero wait states; the trade is one setup cycle of read latency
  assign PREADY = 1'b1;
  assign PRDATA = st_reg.prdata;
  assign PSLVERR = st_reg.pslverr && PSEL && PENABLE;
  assign ACK_TX_START = st_reg.ack_start;
  assign RX_START_IRQ = st_reg.rx_start;
  assign ADDR_MATCH_IRQ = st_reg.ami;
  assign RX_END_IRQ = st_reg.rx_end;
  // busy until ack or frame done
  assign RX_BUSY = (st_reg.fsm != ST_IDLE);

endmodule // auto_ack_frame_filter

//--- verif/aack_checker_sva.sv
// assertion checker for the auto-ack frame filter
`timescale 1ns/1ps
module aack_checker import aack_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic RX_SFD,
  input wire logic RX_DONE,
  input wire logic ACK_TX_START,
  input wire logic RX_START_IRQ,
  input wire logic ADDR_MATCH_IRQ,
  input wire logic RX_END_IRQ,
  input wire logic RX_BUSY
);
  localparam int STD = 12 * SYM_CYCLES;
  localparam int SHORT = 2 * SYM_CYCLES;
  localparam int SLOT = 6 * SYM_CYCLES + 2;
  // short turnaround opens the slot after two symbols
  localparam int SLOT_SHORT = 2 * SYM_CYCLES + 2;
  // ==========================================================
  // helper counters, saturating so long idle gaps never wrap
  logic [9:0] ctrl_reg;
  logic [13:0] done_cnt_reg;
  logic [13:0] trig_cnt_reg;
  logic wr;
  assign wr = PSEL && PENABLE && PWRITE;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= CTRL_RST;
      done_cnt_reg <= '1;
      trig_cnt_reg <= '0;
    end else begin
      if (wr && PADDR == CTRL_OFS) ctrl_reg <= PWDATA[9:0];
      if (RX_DONE) done_cnt_reg <= 14'h1;
      else if (~&done_cnt_reg) done_cnt_reg <= done_cnt_reg + 14'h1;
      // early triggers are ignored by the design, so not counted here
      if (RX_DONE) trig_cnt_reg <= '0;
      else if (wr && PADDR == TRIG_OFS && PWDATA[0]
               && done_cnt_reg >= (ctrl_reg[2] ? SLOT_SHORT : SLOT)) trig_cnt_reg <= 14'h1;
      else if (trig_cnt_reg != 0 && ~&trig_cnt_reg) trig_cnt_reg <= trig_cnt_reg + 14'h1;
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence s_sfd_taken;
    ctrl_reg[0] && RX_SFD && !RX_BUSY;
  endsequence
  sequence s_rx_open;
    RX_BUSY && RX_START_IRQ;
  endsequence
  a_busy_on_sfd: assert property (s_sfd_taken |=> s_rx_open)
    else $error("busy or start pulse missing after sfd");
  a_sfd_mode_off: assert property (!ctrl_reg[0] && RX_SFD && !RX_BUSY |=> !RX_START_IRQ)
    else $error("start pulse with receive mode off");
  a_busy_from_sfd: assert property ($rose(RX_BUSY) |-> $past(RX_SFD))
    else $error("busy rose without sfd");
  a_end_after_done: assert property (RX_END_IRQ |-> $past(RX_DONE))
    else $error("rx end pulse not after frame end");
  a_match_after_done: assert property (ADDR_MATCH_IRQ |-> $past(RX_DONE) && ctrl_reg[9])
    else $error("match pulse without frame end or enable");
  a_std_turnaround: assert property (ACK_TX_START && ctrl_reg[2:1] == 2'b00
    |-> done_cnt_reg inside {[STD:STD+2]})
    else $error("standard ack turnaround wrong");
  a_short_turnaround: assert property (ACK_TX_START && ctrl_reg[2:1] == 2'b10
    |-> done_cnt_reg inside {[SHORT:SHORT+2]})
    else $error("short ack turnaround wrong");
  a_host_starts: assert property (ACK_TX_START && ctrl_reg[1] |-> trig_cnt_reg != 0)
    else $error("slotted ack started without trigger");
  a_trig_delay: assert property (ACK_TX_START && ctrl_reg[1]
    |-> trig_cnt_reg inside {[TRIG_CYCLES:TRIG_CYCLES+2]})
    else $error("slotted ack not 16 us after trigger");
  a_ack_floor: assert property (ACK_TX_START |-> done_cnt_reg >= SHORT)
    else $error("ack earlier than two symbols");
endmodule // aack_checker

bind auto_ack_frame_filter aack_checker aack_checker_i (
  .CLK_SYS(CLK_SYS),
  .RSTN(RSTN),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .RX_SFD(RX_SFD),
  .RX_DONE(RX_DONE),
  .ACK_TX_START(ACK_TX_START),
  .RX_START_IRQ(RX_START_IRQ),
  .ADDR_MATCH_IRQ(ADDR_MATCH_IRQ),
  .RX_END_IRQ(RX_END_IRQ),
  .RX_BUSY(RX_BUSY)
);

//--- verif/remote_node.sv
// model of the remote radio node and of the ack transmitter
`timescale 1ns/1ps
module remote_node #(
  parameter int ACK_CYCLES = 40
) (
  input wire logic clk,
  input wire logic ack_start,
  output logic sfd,
  output logic valid,
  output logic [7:0] rx_byte,
  output logic done,
  output logic fcs_ok,
  output logic tx_done
);
  int ack_left;
  initial begin
    sfd = 1'b0;
    valid = 1'b0;
    rx_byte = 8'h00;
    done = 1'b0;
    fcs_ok = 1'b0;
    tx_done = 1'b0;
    ack_left = 0;
  end
  // released lanes show the inverse, never a stale value
  task automatic send(input logic [7:0] f[$], input logic ok);
    @(posedge clk) sfd <= 1'b1;
    @(posedge clk) sfd <= 1'b0;
    foreach (f[i]) begin
      @(posedge clk);
      valid <= 1'b1;
      rx_byte <= f[i];
      @(posedge clk);
      valid <= 1'b0;
      rx_byte <= ~f[i];
    end
    @(posedge clk);
    done <= 1'b1;
    fcs_ok <= ok;
    @(posedge clk);
    done <= 1'b0;
    fcs_ok <= ~ok;
  endtask
  // ack air time, then one done pulse
  always @(posedge clk) begin
    tx_done <= 1'b0;
    if (ack_start) ack_left <= ACK_CYCLES;
    else if (ack_left == 1) begin
      tx_done <= 1'b1;
      ack_left <= 0;
    end else if (ack_left > 1) ack_left <= ack_left - 1;
  end
endmodule // remote_node

//--- verif/auto_ack_frame_filter_tb.sv
// self-checking bench for the auto-ack frame filter
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    checked++; \
    if ((gt) !== (ex)) begin \
      n_errors++; \
      $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
    end \
  end
module auto_ack_frame_filter_tb import aack_pkg::*;;
  typedef struct packed {
    logic [9:0] ctrl;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [15:0] pan;
    logic [15:0] adr;
    logic ami;
    logic fin;
  } row_t;
  logic CLK_SYS, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0] PADDR, RX_BYTE;
  logic [31:0] PWDATA, PRDATA, rd;
  logic RX_SFD, RX_VALID, RX_DONE, RX_FCS_OK, TX_DONE, ACK_TX_START;
  logic RX_START_IRQ, ADDR_MATCH_IRQ, RX_END_IRQ, RX_BUSY, er;
  logic g_ami, g_end, g_start, g_busy, g_ack;
  int n_errors, checked, cycles, done_cyc, ack_cyc, tw, lo, d;
  // ==========================================================
  // frame table: ctrl, fcf, pan, address, match, end
  row_t rows [15] = '{
    '{10'h241, 8'h01, 8'h08, 16'h1234, 16'h0001, 1'b1, 1'b1},
    '{10'h241, 8'h01, 8'h08, 16'h1234, 16'h0002, 1'b0, 1'b0},
    '{10'h241, 8'h01, 8'h08, 16'h4321, 16'h0001, 1'b0, 1'b0},
    '{10'h241, 8'h01, 8'h08, 16'hffff, 16'hffff, 1'b1, 1'b1},
    '{10'h241, 8'h02, 8'h00, 16'h1234, 16'h0001, 1'b0, 1'b0},
    '{10'h241, 8'h04, 8'h08, 16'h1234, 16'h0001, 1'b0, 1'b0},
    '{10'h251, 8'h04, 8'h08, 16'h1234, 16'h0002, 1'b0, 1'b1},
    '{10'h241, 8'h01, 8'h38, 16'h1234, 16'h0001, 1'b0, 1'b0},
    '{10'h2c1, 8'h01, 8'h38, 16'h1234, 16'h0001, 1'b1, 1'b1},
    '{10'h249, 8'h01, 8'h80, 16'h1234, 16'h0005, 1'b1, 1'b1},
    '{10'h241, 8'h01, 8'h80, 16'h1234, 16'h0005, 1'b0, 1'b0},
    '{10'h241, 8'h00, 8'h80, 16'h1234, 16'h0005, 1'b1, 1'b1},
    '{10'h241, 8'h00, 8'h80, 16'h4321, 16'h0005, 1'b0, 1'b0},
    '{10'h041, 8'h01, 8'h08, 16'h1234, 16'h0001, 1'b0, 1'b1},
    '{10'h241, 8'h01, 8'h00, 16'h1234, 16'h0001, 1'b0, 1'b1}
  };
  auto_ack_frame_filter auto_ack_frame_filter_i (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RX_SFD(RX_SFD), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE), .RX_DONE(RX_DONE),
    .RX_FCS_OK(RX_FCS_OK), .TX_DONE(TX_DONE), .ACK_TX_START(ACK_TX_START),
    .RX_START_IRQ(RX_START_IRQ), .ADDR_MATCH_IRQ(ADDR_MATCH_IRQ),
    .RX_END_IRQ(RX_END_IRQ), .RX_BUSY(RX_BUSY)
  );
  remote_node remote_node_i (
    .clk(CLK_SYS), .ack_start(ACK_TX_START), .sfd(RX_SFD), .valid(RX_VALID),
    .rx_byte(RX_BYTE), .done(RX_DONE), .fcs_ok(RX_FCS_OK), .tx_done(TX_DONE)
  );
  always #10 CLK_SYS = ~CLK_SYS;
  // sticky event flags, so one-cycle pulses are never missed
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (ADDR_MATCH_IRQ) g_ami <= 1'b1;
    if (RX_END_IRQ) g_end <= 1'b1;
    if (RX_START_IRQ) g_start <= 1'b1;
    if (RX_BUSY) g_busy <= 1'b1;
    if (ACK_TX_START) g_ack <= 1'b1;
    if (ACK_TX_START) ack_cyc <= cycles;
    if (RX_DONE) done_cyc <= cycles;
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK_SYS) PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // one idle edge, so a following call never drives psel twice in a step
    @(posedge CLK_SYS);
  endtask
  task automatic frame(input row_t r);
    logic [7:0] q[$];
    q = {r.b0, r.b1, 8'h05, r.pan[7:0], r.pan[15:8], r.adr[7:0], r.adr[15:8], 8'h00, 8'h00};
    {g_ami, g_end, g_start, g_busy, g_ack} <= '0;
    remote_node_i.send(q, 1'b1);
    repeat (3) @(posedge CLK_SYS);
  endtask
  task automatic wait_ack();
    for (int k = 0; k < 12000 && !g_ack; k++) @(posedge CLK_SYS);
  endtask
  initial begin
    {CLK_SYS, RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {g_ami, g_end, g_start, g_busy, g_ack} = '0;
    {n_errors, checked, cycles, done_cyc, ack_cyc} = '0;
    repeat (6) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    @(posedge CLK_SYS);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl reset", {22'h0, CTRL_RST}, rd);
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("trac reset", TRAC_INVALID, rd[6:4]);
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped err", 1'b1, er);
    // address fields set before the filter is relied upon
    apb(1'b1, PAN_OFS, 32'h1234);
    apb(1'b1, SHORT_OFS, 32'h1);
    frame(rows[0]);
    `CHK("start mode off", 1'b0, g_start);
    foreach (rows[i]) begin
      apb(1'b1, CTRL_OFS, {22'h0, rows[i].ctrl});
      frame(rows[i]);
      `CHK("match irq", rows[i].ami, g_ami);
      `CHK("rx end irq", rows[i].fin, g_end);
      `CHK("busy seen", 1'b1, g_busy && g_start);
    end
    // unslotted turnaround, both selections
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, CTRL_OFS, 32'h241 | (s << 2));
      frame('{10'h241, 8'h21, 8'h08, 16'h1234, 16'h0001, 1'b1, 1'b1});
      wait_ack();
      lo = (s == 1 ? 2 : 12) * SYM_CYCLES;
      d = ack_cyc - done_cyc;
      `CHK("ack delay", 1'b1, g_ack && d >= lo && d <= lo + 2);
      repeat (60) @(posedge CLK_SYS);
    end
    // slotted, both selections: an early trigger must be ignored
    for (int s = 0; s < 2; s++) begin
      apb(1'b1, CTRL_OFS, 32'h243 | (s << 2));
      frame('{10'h243, 8'h21, 8'h08, 16'h1234, 16'h0001, 1'b1, 1'b1});
      repeat (SYM_CYCLES) @(posedge CLK_SYS);
      apb(1'b1, TRIG_OFS, 32'h1);
      rd = '0;
      for (int k = 0; k < 2000 && rd[6:4] !== TRAC_ACK_WAITING; k++) apb(1'b0, STATUS_OFS, 32'h0);
      lo = (s == 1 ? 2 : 6) * SYM_CYCLES;
      d = cycles - done_cyc;
      `CHK("slot wait time", 1'b1, d >= lo && d <= lo + 10);
      `CHK("no self start", 1'b0, g_ack);
      apb(1'b1, TRIG_OFS, 32'h1);
      tw = cycles;
      wait_ack();
      d = ack_cyc - tw;
      `CHK("trig delay", 1'b1, g_ack && d >= TRIG_CYCLES && d <= TRIG_CYCLES + 2);
      repeat (60) @(posedge CLK_SYS);
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("trac success", TRAC_SUCCESS, rd[6:4]);
    end
    report_and_stop();
  end
endmodule // auto_ack_frame_filter_tb
